// ==== rtl/general_word_unit.sv ====
// The 16-bit general word register with its byte, swapped and sign-extended views.
`default_nettype none
module general_word_unit
   import xfer_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic wr_word,
   input wire logic wr_high,
   input wire logic wr_low,
   input wire logic [WORD_W-1:0] wr_data,
   output logic [WORD_W-1:0] word,
   output logic [WORD_W-1:0] swapped,
   output logic [WORD_W-1:0] signext
);
   logic [BYTE_W-1:0] high_q;
   logic [BYTE_W-1:0] low_q;
   logic [BYTE_W-1:0] high_d;
   logic [BYTE_W-1:0] low_d;

   // A byte write touches only its own byte; a word write takes both.
   assign high_d = wr_word ? wr_data[WORD_W-1:BYTE_W] : // RULE3
                   (wr_high ? wr_data[BYTE_W-1:0] : high_q); // RULE19
   assign low_d = (wr_word || wr_low) ? wr_data[BYTE_W-1:0] : low_q; // RULE3 RULE19

   // Byte halves are stored separately so a byte write cannot disturb the other half.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         high_q <= WORD_RESET[WORD_W-1:BYTE_W];
         low_q <= WORD_RESET[BYTE_W-1:0];
      end
      else
      begin
         high_q <= high_d;
         low_q <= low_d;
      end
   end

   // Read views are pure wiring of the stored bytes.
   assign word = {high_q, low_q};
   assign swapped = {low_q, high_q}; // RULE4
   assign signext = {{BYTE_W{low_q[BYTE_W-1]}}, low_q}; // RULE5

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_high_keeps_low: assert property ( // RULE19
      wr_high && !wr_word && !wr_low |=> low_q == $past(low_q))
      else $error("High byte write disturbed the low byte.");
   a_swap_after_word: assert property ( // RULE4
      wr_word |=> swapped == {$past(wr_data[7:0]), $past(wr_data[15:8])})
      else $error("Swapped view does not follow the written word.");
   a_signext_low: assert property ( // RULE5
      wr_low && !wr_word |=> signext[15:8] == {8{$past(wr_data[7])}})
      else $error("Sign-extended view upper byte is wrong.");
endmodule
`default_nettype wire

// ==== rtl/reg_transfer_unit.sv ====
// Register-transfer unit: moves, prefix handling, bit operations, carry copies, accumulators.
`default_nettype none
// Behaviour
// RULE1: Equal-width move with destination 0-7h and source 0-Fh completes in one cycle.
// RULE2: Destination above 7h or source above Fh needs a preceding prefix load.
// RULE3: Provide a 16-bit general word whose bytes are separately readable and writable.
// RULE4: Read-only swapped view returns the general word with bytes exchanged.
// RULE5: Another view returns the general low byte sign-extended to sixteen bits.
// RULE6: Word source into byte destination delivers the source low byte.
// RULE7: Byte source into word destination takes its upper byte from prefix data.
// RULE8: Byte concatenation costs one extra cycle for high source or destination index.
// RULE9: Low-byte-only write costs one more cycle when destination index exceeds 0Fh.
// RULE10: Byte into word without loaded prefix leaves upper byte at 00h.
// RULE11: Bit set or clear works on low 8 bits in modules 0h-5h and 8h.
// RULE12: Bit set or clear leaves a 16-bit target's upper byte unchanged.
// RULE13: Unsupported bit target gets prefix data high and the bit mask low.
// RULE14: Bit set or clear above destination index 07h needs a prefix load.
// RULE15: Carry copy takes a low-byte bit of any register or any accumulator bit; the code gives all 16 bits only for the working accumulator.
// RULE16: Carry copy from source index above 15h needs a prefix load; the code needs one above 0Fh.
// RULE17: Accumulators are word wide, eight of them, any one selectable as working.
// RULE18: Prefix data lasts one cycle and then returns to zero.
// RULE19: Writing one general byte view leaves the other byte unchanged.
module reg_transfer_unit
   import xfer_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic op_valid,
   input wire op_kind_t op_kind,
   input wire logic [PFX_NUM_W-1:0] pfx_num,
   input wire logic [MOD_W-1:0] dst_mod,
   input wire logic [DST_FIELD_W-1:0] dst_field,
   input wire logic [MOD_W-1:0] src_mod,
   input wire logic [SRC_FIELD_W-1:0] src_field,
   input wire logic [BIT_SEL_W-1:0] bit_sel,
   input wire logic [BYTE_W-1:0] imm_byte,
   output logic [MOD_W-1:0] ext_rd_mod,
   output logic [IDX_W-1:0] ext_rd_idx,
   input wire logic [WORD_W-1:0] ext_rd_data,
   input wire logic ext_rd_wide,
   input wire logic [WORD_W-1:0] ext_dst_rd_data,
   input wire logic ext_dst_wide,
   input wire logic ext_dst_bitop,
   output logic ext_wr_en,
   output logic [MOD_W-1:0] ext_wr_mod,
   output logic [IDX_W-1:0] ext_wr_idx,
   output logic [WORD_W-1:0] ext_wr_data,
   output logic carry,
   output logic [AP_W-1:0] acc_pointer,
   output logic [ACC_W-1:0] working_acc
);
   logic [BYTE_W-1:0] pfx_data_q;
   logic [BYTE_W-1:0] pfx_data_d;
   logic [PFX_NUM_W-1:0] pfx_num_q;
   logic [PFX_NUM_W-1:0] pfx_num_d;
   logic [ACC_W-1:0] acc_q [NUM_ACC];
   logic [AP_W-1:0] ap_q;
   logic [AP_W-1:0] ap_d;
   logic carry_q;
   logic carry_d;
   logic [WORD_W-1:0] gen_word;
   logic [WORD_W-1:0] gen_swapped;
   logic [WORD_W-1:0] gen_signext;

   // True when a module and index name a register held inside this unit.
   function automatic logic int_hit(input logic [MOD_W-1:0] m, input logic [IDX_W-1:0] i);
      logic acc_ok;
      logic sys_ok;
      logic gen_ok;
      acc_ok = (m == MOD_ACC) && (i < IDX_W'(NUM_ACC));
      sys_ok = (m == MOD_SYS) && ((i == IDX_WORKING) || (i == IDX_AP));
      gen_ok = (m == MOD_GEN) && (i >= IDX_GEN_WORD) && (i <= IDX_GEN_SIGNEXT);
      return acc_ok || sys_ok || gen_ok;
   endfunction

   // Width of an internal register: only the pointer and the two general bytes are narrow.
   function automatic logic int_wide(input logic [MOD_W-1:0] m, input logic [IDX_W-1:0] i);
      logic narrow;
      narrow = ((m == MOD_SYS) && (i == IDX_AP)) ||
               ((m == MOD_GEN) && ((i == IDX_GEN_HIGH) || (i == IDX_GEN_LOW)));
      return !narrow;
   endfunction

   // Value of an internal register; narrow ones sit in the low byte.
   function automatic logic [WORD_W-1:0] int_read(input logic [MOD_W-1:0] m,
                                                  input logic [IDX_W-1:0] i);
      logic [WORD_W-1:0] v;
      v = WORD_RESET;
      if (m == MOD_ACC && i < IDX_W'(NUM_ACC))
         v = acc_q[i[ACC_SEL_W-1:0]];
      else if (m == MOD_SYS && i == IDX_WORKING)
         v = acc_q[ap_q[ACC_SEL_W-1:0]];
      else if (m == MOD_SYS && i == IDX_AP)
         v = {{(WORD_W-AP_W){1'b0}}, ap_q};
      else if (m == MOD_GEN && i == IDX_GEN_WORD)
         v = gen_word;
      else if (m == MOD_GEN && i == IDX_GEN_HIGH)
         v = {BYTE_ZERO, gen_word[WORD_W-1:BYTE_W]};
      else if (m == MOD_GEN && i == IDX_GEN_LOW)
         v = {BYTE_ZERO, gen_word[BYTE_W-1:0]};
      else if (m == MOD_GEN && i == IDX_GEN_SWAP)
         v = gen_swapped;
      else if (m == MOD_GEN && i == IDX_GEN_SIGNEXT)
         v = gen_signext;
      return v;
   endfunction

   // Operation decode.
   logic is_prefix;
   logic is_move;
   logic is_imm;
   logic is_bit_set;
   logic is_bit_op;
   logic is_carry_op;
   assign is_prefix = op_valid && (op_kind == OP_PREFIX);
   assign is_move = op_valid && (op_kind == OP_MOVE);
   assign is_imm = op_valid && (op_kind == OP_IMM);
   assign is_bit_set = op_valid && (op_kind == OP_BIT_SET);
   assign is_bit_op = is_bit_set || (op_valid && (op_kind == OP_BIT_CLR));
   assign is_carry_op = op_valid && (op_kind == OP_BIT_CARRY);

   // Full indices: the instruction carries the low bits, the prefix the high ones.
   logic [IDX_W-1:0] src_idx;
   logic [IDX_W-1:0] dst_idx;
   assign src_idx = {pfx_num_q[PFX_SRC_B4], src_field}; // RULE2 RULE16
   assign dst_idx = {pfx_num_q[PFX_DST_B4], pfx_num_q[PFX_DST_B3], // RULE2 RULE14
                     dst_field}; // RULE8 RULE9

   // Source selection between internal registers and the external read port.
   logic src_int;
   logic [WORD_W-1:0] src_val;
   logic src_wide;
   assign src_int = int_hit(src_mod, src_idx);
   // A process rather than an assign, so that a change in a register the function reads
   // wakes it up even while the source address stays the same.
   always_comb
   begin
      src_val = src_int ? int_read(src_mod, src_idx) : ext_rd_data;
   end
   assign src_wide = src_int ? int_wide(src_mod, src_idx) : ext_rd_wide;
   assign ext_rd_mod = src_mod;
   assign ext_rd_idx = src_idx;

   // Destination attributes; its current value feeds bit read-modify-write.
   logic dst_int;
   logic dst_wide;
   logic [WORD_W-1:0] dst_cur;
   assign dst_int = int_hit(dst_mod, dst_idx);
   assign dst_wide = dst_int ? int_wide(dst_mod, dst_idx) : ext_dst_wide;
   // Same reason as the source side: the function reads registers that are not its arguments.
   always_comb
   begin
      dst_cur = dst_int ? int_read(dst_mod, dst_idx) : ext_dst_rd_data;
   end

   // Move data: an immediate counts as a byte source.
   logic [BYTE_W-1:0] src_low;
   logic src_is_wide;
   logic [WORD_W-1:0] move_data;
   assign src_low = is_imm ? imm_byte : src_val[BYTE_W-1:0];
   assign src_is_wide = is_move && src_wide;
   assign move_data = !dst_wide ? {BYTE_ZERO, src_low} : // RULE6
                      src_is_wide ? src_val : // RULE1
                      {pfx_data_q, src_low}; // RULE7 RULE10 RULE8

   // Bit set/clear: supported targets keep their upper byte, others get prefix and mask.
   logic [BYTE_W-1:0] bit_mask;
   logic [BYTE_W-1:0] bit_low;
   logic bit_module_ok;
   logic bit_supported;
   logic [WORD_W-1:0] bit_data;
   assign bit_mask = BIT_ONE << bit_sel[2:0];
   assign bit_low = is_bit_set ? (dst_cur[BYTE_W-1:0] | bit_mask) :
                    (dst_cur[BYTE_W-1:0] & ~bit_mask);
   assign bit_module_ok = (dst_mod <= MOD_PERIPH_MAX) || (dst_mod == MOD_SYS); // RULE11
   assign bit_supported = dst_int || ext_dst_bitop;
   assign bit_data = bit_supported ? {dst_cur[WORD_W-1:BYTE_W], bit_low} : // RULE12
                     {pfx_data_q, is_bit_set ? bit_mask : ~bit_mask}; // RULE13

   // One write per cycle; bit operations outside the allowed modules are dropped.
   logic wr_now;
   logic [WORD_W-1:0] wr_data;
   assign wr_now = is_move || is_imm || (is_bit_op && bit_module_ok); // RULE1 RULE11
   assign wr_data = is_bit_op ? bit_data : move_data;
   assign ext_wr_en = wr_now && !dst_int;
   assign ext_wr_mod = dst_mod;
   assign ext_wr_idx = dst_idx;
   assign ext_wr_data = wr_data;

   // Internal write strobes.
   logic wr_acc;
   logic wr_working;
   logic wr_ap;
   logic wr_gen_word;
   logic wr_gen_high;
   logic wr_gen_low;
   assign wr_acc = wr_now && (dst_mod == MOD_ACC) && (dst_idx < IDX_W'(NUM_ACC));
   assign wr_working = wr_now && (dst_mod == MOD_SYS) && (dst_idx == IDX_WORKING);
   assign wr_ap = wr_now && (dst_mod == MOD_SYS) && (dst_idx == IDX_AP);
   assign wr_gen_word = wr_now && (dst_mod == MOD_GEN) && (dst_idx == IDX_GEN_WORD);
   assign wr_gen_high = wr_now && (dst_mod == MOD_GEN) && (dst_idx == IDX_GEN_HIGH);
   assign wr_gen_low = wr_now && (dst_mod == MOD_GEN) && (dst_idx == IDX_GEN_LOW);

   // The accumulator addressed by a write, either by number or through the pointer.
   logic [ACC_SEL_W-1:0] acc_wr_sel;
   assign acc_wr_sel = wr_working ? ap_q[ACC_SEL_W-1:0] : dst_idx[ACC_SEL_W-1:0]; // RULE17

   // Carry copy: the working accumulator offers every bit, anything else its low byte.
   logic src_is_working;
   logic carry_bit;
   assign src_is_working = (src_mod == MOD_SYS) && (src_idx == IDX_WORKING);
   assign carry_bit = src_is_working ? src_val[bit_sel] : src_val[bit_sel[2:0]]; // RULE15
   assign carry_d = is_carry_op ? carry_bit : carry_q; // RULE15

   // Prefix data lives only until the next cycle, so it steers one instruction.
   assign pfx_data_d = is_prefix ? imm_byte : BYTE_ZERO; // RULE18
   assign pfx_num_d = is_prefix ? pfx_num : PFX_NUM_ZERO; // RULE18
   assign ap_d = wr_ap ? wr_data[AP_W-1:0] : ap_q;

   // Prefix, pointer and carry state.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pfx_data_q <= BYTE_ZERO;
         pfx_num_q <= PFX_NUM_ZERO;
         ap_q <= AP_RESET;
         carry_q <= 1'b0;
      end
      else
      begin
         pfx_data_q <= pfx_data_d;
         pfx_num_q <= pfx_num_d;
         ap_q <= ap_d;
         carry_q <= carry_d;
      end
   end

   // Accumulator bank; reset clears every entry so reads are never undefined.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         for (int k = 0; k < NUM_ACC; k++)
            acc_q[k] <= WORD_RESET;
      end
      else if (wr_acc || wr_working)
      begin
         acc_q[acc_wr_sel] <= wr_data; // RULE17
      end
   end

   general_word_unit u_general_word (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wr_word(wr_gen_word),
      .wr_high(wr_gen_high),
      .wr_low(wr_gen_low),
      .wr_data(wr_data),
      .word(gen_word),
      .swapped(gen_swapped),
      .signext(gen_signext)
   );

   // Status outputs.
   assign carry = carry_q;
   assign acc_pointer = ap_q;
   assign working_acc = acc_q[ap_q[ACC_SEL_W-1:0]];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_prefix_one_cycle: assert property ( // RULE18
      is_prefix ##1 !is_prefix |=> pfx_data_q == 8'h00 && pfx_num_q == 3'h0)
      else $error("Prefix data outlived the following instruction.");
   a_prefix_captured: assert property (is_prefix |=> pfx_data_q == $past(imm_byte)) // RULE18
      else $error("Prefix data not captured.");
   a_equal_move_now: assert property ( // RULE1
      is_move && dst_wide && src_wide |-> wr_now && wr_data == src_val)
      else $error("Equal-width move not done in its cycle.");
   a_high_index_prefixed: assert property ( // RULE2 RULE14
      ext_wr_en && ext_wr_idx > 5'h07 |-> $past(is_prefix))
      else $error("High destination index written without a prefix.");
   a_narrow_gets_low: assert property ( // RULE6
      is_move && !dst_wide |-> wr_data == {8'h00, src_val[7:0]})
      else $error("Byte destination did not get the source low byte.");
   a_concat_upper: assert property ( // RULE7
      is_move && dst_wide && !src_wide |-> wr_data[15:8] == pfx_data_q)
      else $error("Word destination upper byte not taken from prefix.");
   a_no_prefix_zero: assert property ( // RULE10
      $past(!is_prefix) && is_move && dst_wide && !src_wide |-> wr_data[15:8] == 8'h00)
      else $error("Upper byte not zero without a prefix.");
   a_bit_module_gate: assert property (is_bit_op && !bit_module_ok |-> !wr_now) // RULE11
      else $error("Bit operation reached a module that does not allow it.");
   a_bit_keeps_upper: assert property ( // RULE12
      ext_wr_en && is_bit_op && ext_dst_bitop |-> ext_wr_data[15:8] == ext_dst_rd_data[15:8])
      else $error("Bit operation changed the upper byte.");
   a_bit_unsupported: assert property ( // RULE13
      ext_wr_en && is_bit_set && !ext_dst_bitop |-> ext_wr_data == {pfx_data_q, bit_mask})
      else $error("Unsupported bit target not written with prefix and mask.");
   a_carry_copy: assert property ( // RULE15
      is_carry_op && !src_is_working |=> carry == $past(src_val[bit_sel[2:0]]))
      else $error("Carry did not receive the selected source bit.");
   a_carry_source_idx: assert property ( // RULE16
      is_carry_op && ext_rd_idx > 5'h0F |-> $past(is_prefix))
      else $error("High carry source index used without a prefix.");
endmodule
`default_nettype wire

// ==== rtl/xfer_pkg.sv ====
// Constants and types shared by the register-transfer unit and its general word register.
`default_nettype none
package xfer_pkg;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int ACC_W = 16;
   localparam int NUM_ACC = 8;
   localparam int ACC_SEL_W = 3;
   localparam int AP_W = 4;
   localparam int MOD_W = 4;
   localparam int IDX_W = 5;
   localparam int DST_FIELD_W = 3;
   localparam int SRC_FIELD_W = 4;
   localparam int PFX_NUM_W = 3;
   localparam int BIT_SEL_W = 4;

   // Prefix index bits that extend the register indices of the next instruction.
   localparam int PFX_SRC_B4 = 0;
   localparam int PFX_DST_B3 = 1;
   localparam int PFX_DST_B4 = 2;

   // Last peripheral module, then register modules and sub-indices held inside this unit.
   localparam logic [3:0] MOD_PERIPH_MAX = 4'h5;
   localparam logic [3:0] MOD_SYS = 4'h8;
   localparam logic [3:0] MOD_ACC = 4'hA;
   localparam logic [3:0] MOD_GEN = 4'hD;
   localparam logic [4:0] IDX_WORKING = 5'h00;
   localparam logic [4:0] IDX_AP = 5'h01;
   localparam logic [4:0] IDX_GEN_WORD = 5'h02;
   localparam logic [4:0] IDX_GEN_HIGH = 5'h03;
   localparam logic [4:0] IDX_GEN_LOW = 5'h04;
   localparam logic [4:0] IDX_GEN_SWAP = 5'h05;
   localparam logic [4:0] IDX_GEN_SIGNEXT = 5'h06;

   // Reset values and the bit-mask seed.
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BIT_ONE = 8'h01;
   localparam logic [3:0] AP_RESET = 4'h0;
   localparam logic [2:0] PFX_NUM_ZERO = 3'h0;

   typedef enum logic [2:0] {
      OP_NOP = 3'h0,
      OP_PREFIX = 3'h1,
      OP_MOVE = 3'h2,
      OP_IMM = 3'h3,
      OP_BIT_SET = 3'h4,
      OP_BIT_CLR = 3'h5,
      OP_BIT_CARRY = 3'h6
   } op_kind_t;
endpackage
`default_nettype wire

// ==== verification/ext_regs_model.sv ====
// Behavioural model of the external register modules beside the transfer unit.
`default_nettype none
module ext_regs_model
   import xfer_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [MOD_W-1:0] rd_mod,
   input wire logic [IDX_W-1:0] rd_idx,
   input wire logic wr_en,
   input wire logic [MOD_W-1:0] wr_mod,
   input wire logic [IDX_W-1:0] wr_idx,
   input wire logic [WORD_W-1:0] wr_data,
   output logic [WORD_W-1:0] rd_data,
   output logic rd_wide,
   output logic [WORD_W-1:0] dst_data,
   output logic dst_wide,
   output logic dst_bitop
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [WORD_W-1:0] mem [0:511];
   // Even indices are word registers, odd ones byte registers.
   assign rd_data = mem[{rd_mod, rd_idx}];
   assign rd_wide = ~rd_idx[0];
   assign dst_data = mem[{wr_mod, wr_idx}];
   assign dst_wide = ~wr_idx[0];
   // Index 7 lacks bit support so the mask fallback path gets exercised.
   assign dst_bitop = (wr_mod <= MOD_PERIPH_MAX || wr_mod == MOD_SYS) && wr_idx != 5'h07;
   // A byte register keeps only its low byte, so its upper byte always reads as zero.
   always_ff @(posedge sys_clk)
   begin
      if (wr_en)
      begin
         mem[{wr_mod, wr_idx}] <= dst_wide ? wr_data : {8'h00, wr_data[7:0]};
      end
   end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Directed testbench for the register-transfer unit and its external registers.
`default_nettype none
module testbench
   import xfer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic op_valid = 1'b0;
   op_kind_t op_kind = OP_NOP;
   logic [2:0] pfx_num = 3'h0;
   logic [3:0] dst_mod = 4'h0;
   logic [2:0] dst_field = 3'h0;
   logic [3:0] src_mod = 4'h0;
   logic [3:0] src_field = 4'h0;
   logic [3:0] bit_sel = 4'h0;
   logic [7:0] imm_byte = 8'h00;
   logic [3:0] rd_mod, wr_mod, acc_pointer;
   logic [4:0] rd_idx, wr_idx;
   logic [15:0] rd_data, dst_data, wr_data, working_acc;
   logic rd_wide, dst_wide, dst_bitop, wr_en, carry;
   int bad_count = 0;
   int comparisons = 0;

   reg_transfer_unit dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .op_valid(op_valid),
      .op_kind(op_kind), .pfx_num(pfx_num), .dst_mod(dst_mod), .dst_field(dst_field),
      .src_mod(src_mod), .src_field(src_field), .bit_sel(bit_sel), .imm_byte(imm_byte),
      .ext_rd_mod(rd_mod), .ext_rd_idx(rd_idx), .ext_rd_data(rd_data), .ext_rd_wide(rd_wide),
      .ext_dst_rd_data(dst_data), .ext_dst_wide(dst_wide), .ext_dst_bitop(dst_bitop),
      .ext_wr_en(wr_en), .ext_wr_mod(wr_mod), .ext_wr_idx(wr_idx), .ext_wr_data(wr_data),
      .carry(carry), .acc_pointer(acc_pointer), .working_acc(working_acc));
   ext_regs_model part_u (.sys_clk(sys_clk), .rd_mod(rd_mod), .rd_idx(rd_idx),
      .wr_en(wr_en), .wr_mod(wr_mod), .wr_idx(wr_idx), .wr_data(wr_data),
      .rd_data(rd_data), .rd_wide(rd_wide), .dst_data(dst_data), .dst_wide(dst_wide),
      .dst_bitop(dst_bitop));

   // Free-running core clock, 100 ns period.
   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
      begin
         $display("== PASSED ==");
      end
      else
      begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Presents one op at the falling edge; combinational answers are settled 1 ns later.
   task automatic go(input op_kind_t k, input logic [2:0] p, input logic [3:0] dm,
                     input logic [2:0] df, input logic [3:0] sm, input logic [3:0] sf,
                     input logic [3:0] bs, input logic [7:0] im);
      @(negedge sys_clk);
      op_valid = 1'b1;
      op_kind = k;
      pfx_num = p;
      dst_mod = dm;
      dst_field = df;
      src_mod = sm;
      src_field = sf;
      bit_sel = bs;
      imm_byte = im;
      #1;
   endtask

   // An idle cycle lets registered results land and drops any pending prefix.
   task automatic nop();
      @(negedge sys_clk);
      op_valid = 1'b0;
      #1;
   endtask

   task automatic pf(input logic [2:0] p, input logic [7:0] d);
      go(OP_PREFIX, p, 4'h0, 3'h0, 4'h0, 4'h0, 4'h0, d);
   endtask

   task automatic mv(input logic [3:0] dm, input logic [2:0] df, input logic [3:0] sm,
                     input logic [3:0] sf);
      go(OP_MOVE, 3'h0, dm, df, sm, sf, 4'h0, 8'h00);
   endtask

   task automatic im(input logic [3:0] dm, input logic [2:0] df, input logic [7:0] d);
      go(OP_IMM, 3'h0, dm, df, 4'h0, 4'h0, 4'h0, d);
   endtask

   task automatic bt(input op_kind_t k, input logic [3:0] dm, input logic [2:0] df,
                     input logic [3:0] bs);
      go(k, 3'h0, dm, df, 4'h0, 4'h0, bs, 8'h00);
   endtask

   task automatic cy(input logic [3:0] sm, input logic [3:0] sf, input logic [3:0] bs);
      go(OP_BIT_CARRY, 3'h0, 4'h0, 3'h0, sm, sf, bs, 8'h00);
   endtask

   // The write strobe, its index and its data are only meaningful together.
   task automatic cw(input logic [4:0] idx, input logic [15:0] d);
      chk({15'h0, wr_en}, 16'h0001);
      chk({12'h0, wr_mod}, {12'h0, dst_mod});
      chk({11'h0, wr_idx}, {11'h0, idx});
      chk(wr_data, d);
   endtask

   // Cuts a hung run short.
   initial
   begin
      repeat (2000) @(posedge sys_clk);
      bad_count++;
      close_out();
   end

   initial
   begin
      part_u.mem[9'h002] = 16'h1234;
      part_u.mem[9'h003] = 16'h0056;
      part_u.mem[9'h010] = 16'hBEEF;
      part_u.mem[9'h013] = 16'h0077;
      part_u.mem[9'h022] = 16'hF0F0;
      part_u.mem[9'h028] = 16'h5500;
      part_u.mem[9'h043] = 16'h0080;
      part_u.mem[9'h053] = 16'h0008;
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      chk({15'h0, carry}, 16'h0000);
      chk({12'h0, acc_pointer}, 16'h0000);
      chk(working_acc, 16'h0000);
      mv(4'h0, 3'h4, MOD_GEN, 4'h2);
      cw(5'h04, 16'h0000);
      // Plain moves and index extension through the prefix.
      mv(4'h0, 3'h4, 4'h0, 4'h2);
      cw(5'h04, 16'h1234);
      mv(4'h0, 3'h5, 4'h0, 4'h2);
      cw(5'h05, 16'h0034);
      pf(3'h2, 8'h00);
      mv(4'h0, 3'h6, 4'h0, 4'h2);
      cw(5'h0E, 16'h1234);
      pf(3'h1, 8'h00);
      mv(4'h0, 3'h4, 4'h0, 4'h0);
      cw(5'h04, 16'hBEEF);
      mv(4'h0, 3'h4, 4'h0, 4'h2);
      cw(5'h04, 16'h1234);
      pf(3'h4, 8'h00);
      nop();
      mv(4'h0, 3'h2, 4'h0, 4'h2);
      cw(5'h02, 16'h1234);
      // Byte concatenation and low-byte-only moves into words.
      pf(3'h0, 8'hAB);
      mv(4'h0, 3'h4, 4'h0, 4'h3);
      cw(5'h04, 16'hAB56);
      mv(4'h0, 3'h4, 4'h0, 4'h3);
      cw(5'h04, 16'h0056);
      pf(3'h5, 8'hAB);
      mv(4'h0, 3'h0, 4'h0, 4'h3);
      cw(5'h10, 16'hAB77);
      // Word at index 10h goes through the general word; then only its low byte is replaced.
      pf(3'h1, 8'h00);
      mv(MOD_GEN, 3'h2, 4'h0, 4'h0);
      mv(4'h0, 3'h5, MOD_GEN, 4'h3);
      cw(5'h05, 16'h00AB);
      pf(3'h4, 8'hAB);
      mv(4'h0, 3'h0, 4'h0, 4'h3);
      cw(5'h10, 16'hAB56);
      // General word and its views.
      mv(MOD_GEN, 3'h2, 4'h0, 4'h2);
      im(MOD_GEN, 3'h3, 8'h9A);
      im(MOD_GEN, 3'h4, 8'h85);
      mv(4'h0, 3'h4, MOD_GEN, 4'h2);
      cw(5'h04, 16'h9A85);
      mv(4'h0, 3'h4, MOD_GEN, 4'h5);
      cw(5'h04, 16'h859A);
      mv(4'h0, 3'h4, MOD_GEN, 4'h6);
      cw(5'h04, 16'hFF85);
      mv(4'h0, 3'h4, MOD_GEN, 4'h3);
      cw(5'h04, 16'h009A);
      mv(MOD_GEN, 3'h5, 4'h0, 4'h2);
      mv(4'h0, 3'h4, MOD_GEN, 4'h2);
      cw(5'h04, 16'h9A85);
      im(MOD_GEN, 3'h4, 8'h12);
      mv(4'h0, 3'h4, MOD_GEN, 4'h6);
      cw(5'h04, 16'h0012);
      // Bit set and clear, supported and unsupported targets.
      bt(OP_BIT_SET, 4'h1, 3'h2, 4'h0);
      cw(5'h02, 16'hF0F1);
      bt(OP_BIT_CLR, 4'h1, 3'h2, 4'h4);
      cw(5'h02, 16'hF0E1);
      pf(3'h0, 8'h3C);
      bt(OP_BIT_SET, 4'h1, 3'h7, 4'h2);
      cw(5'h07, 16'h3C04);
      bt(OP_BIT_CLR, 4'h1, 3'h7, 4'h2);
      cw(5'h07, 16'h00FB);
      pf(3'h2, 8'h00);
      bt(OP_BIT_SET, 4'h1, 3'h0, 4'h1);
      cw(5'h08, 16'h5502);
      bt(OP_BIT_SET, 4'h6, 3'h0, 4'h0);
      chk({15'h0, wr_en}, 16'h0000);
      bt(OP_BIT_SET, MOD_SYS, 3'h1, 4'h1);
      nop();
      chk({12'h0, acc_pointer}, 16'h0002);
      // Carry copies from registers and from the working accumulator.
      cy(4'h2, 4'h3, 4'h7);
      nop();
      chk({15'h0, carry}, 16'h0001);
      cy(4'h2, 4'h3, 4'h6);
      nop();
      chk({15'h0, carry}, 16'h0000);
      pf(3'h1, 8'h00);
      cy(4'h2, 4'h3, 4'h3);
      chk({12'h0, rd_mod}, 16'h0002);
      chk({11'h0, rd_idx}, 16'h0013);
      nop();
      chk({15'h0, carry}, 16'h0001);
      pf(3'h0, 8'h80);
      im(MOD_ACC, 3'h3, 8'h00);
      im(MOD_SYS, 3'h1, 8'h03);
      nop();
      chk(working_acc, 16'h8000);
      cy(MOD_SYS, 4'h0, 4'hF);
      nop();
      chk({15'h0, carry}, 16'h0001);
      cy(MOD_SYS, 4'h0, 4'hE);
      nop();
      chk({15'h0, carry}, 16'h0000);
      im(MOD_SYS, 3'h1, 8'h07);
      nop();
      chk({12'h0, acc_pointer}, 16'h0007);
      chk(working_acc, 16'h0000);
      close_out();
   end
endmodule
`default_nettype wire
